// ---- logic/def_top.sv ----
// two-stage directional earth fault block with wishbone registers
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RQ1] start rises while current, voltage and angle meet the active pick-up criterion
// [RQ2] trip rises once pick-up has lasted longer than the operate delay
// [RQ3] only fundamental phasors are evaluated; third harmonic rejected over 60 dB
// [RQ4] current angle is measured against the negated zero sequence voltage
// [RQ5] phase-voltage mode: derived voltage, settings scaled to transformer voltage/root 3
// [RQ6] dedicated input mode: measured voltage, settings scaled to its secondary voltage
// [RQ7] ohmic-or-charging mode lets a chosen signal switch submode at run time
// [RQ8] ohmic submode compares resistive current component, half-plane area
// [RQ9] charging submode compares capacitive current component, half-plane area
// [RQ10] sector mode trips only inside offset plus or minus half width
// [RQ11] nondirectional mode checks only selected current amplitude
// [RQ12] each stage watches measured residual or summed phase residual current
// [RQ13] a new start inside intermittent time keeps the accumulated delay
// [RQ14] two stages, each definite time or inverse time
// [RQ15] inverse time shortens delay as current exceeds pick-up further
// [RQ16] measured residual saturates at ten, summed current at fifty times nominal
// [RQ17] four setting groups per stage, active one chosen by signal or manually
// [RQ18] group selector source is none, digital, virtual, indicator, virtual output, key
// [RQ19] shared force flag allows forcing start or trip, clears after five minutes
// [RQ20] stage status reads idle, blocked, started or tripped
// [RQ21] start and trip counters count events and clear on command
// [RQ22] while started, an estimate of time left to trip is shown
// [RQ23] sector half width resets to 88 degrees
// [RQ24] submode control is fixed ohmic, fixed charging, digital or virtual input
// [RQ25] accumulated delay clears when intermittent time passes without new start
// [RQ26] a blocked stage holds start and trip low
//////////////////////////////////////////////////////////////////////////////
module def_top #(
  parameter int unsigned TICK_CYCLES = def_pkg::TICK_CYC,
  parameter int unsigned FORCE_TICKS = def_pkg::FORCE_TICKS
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire def_pkg::def_meas_type meas_i,
  input  wire logic [7:0]           digital_input_n_i,
  input  wire logic [7:0]           virtual_input_n_i,
  input  wire logic [7:0]           indicator_signal_n_i,
  input  wire logic [7:0]           virtual_output_n_i,
  input  wire logic [7:0]           function_key_n_i,
  input  wire logic [1:0]           block_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [8:0]           wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  input  wire logic [3:0]           wb_sel_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  output logic [1:0]                start_o,
  output logic [1:0]                trip_o,
  output logic                      force_o
);
  import def_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // helpers

  // pick one selector signal by source kind and index
  function automatic logic sel_sig(input logic [39:0] v, input def_src_type src,
                                   input logic [2:0] i);
    case (src)
      SRC_DIGITAL:   sel_sig = v[{3'd0, i}];
      SRC_VIRTUAL:   sel_sig = v[{3'd1, i}];
      SRC_INDICATOR: sel_sig = v[{3'd2, i}];
      SRC_VOUT:      sel_sig = v[{3'd3, i}];
      SRC_FKEY:      sel_sig = v[{3'd4, i}];
      default:       sel_sig = 1'b0;
    endcase
  endfunction : sel_sig

  // byte-lane merge of a write
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      wmerge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
    end
  endfunction : wmerge

  // word address inside a stage register window
  function automatic logic in_stage(input logic [8:0] a, input int s);
    in_stage = a[8:6] == 3'(A_STG[8:6] + 3'(s));
  endfunction : in_stage

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic [15:0]         tick_cnt;
  logic                tick;
  logic [19:0]         frc_cnt;
  logic                vmode;
  logic [31:0]         vbase;
  logic [39:0]         sigs;
  logic                req;
  logic                wr;
  logic                mem_hit;
  logic [4:0]          midx;
  logic [31:0]         next_dat;
  def_cfg_type         cfg       [NUM_STAGES];
  logic [1:0]          frc_val   [NUM_STAGES];
  logic [31:0]         grp_mem   [MEM_WORDS];
  logic [31:0]         start_count [NUM_STAGES];
  logic [31:0]         trip_count  [NUM_STAGES];
  logic                start_d   [NUM_STAGES];
  logic                trip_d    [NUM_STAGES];
  def_status_type      status    [NUM_STAGES];
  logic [1:0]          act_grp   [NUM_STAGES];
  def_set_type         set_sel   [NUM_STAGES];
  logic                sub_sig   [NUM_STAGES];
  logic                blk       [NUM_STAGES];
  logic [15:0]         rem       [NUM_STAGES];
  def_submode_type     subm      [NUM_STAGES];

  assign sigs    = {function_key_n_i, virtual_output_n_i, indicator_signal_n_i,
                    virtual_input_n_i, digital_input_n_i};
  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr      = req & wb_we_i;
  assign midx    = 5'(wb_adr_i[8:2] - A_MEM[8:2]);
  assign mem_hit = wb_adr_i[8:2] >= A_MEM[8:2] && wb_adr_i[8:2] < 7'(A_MEM[8:2] + MEM_WORDS);

  //////////////////////////////////////////////////////////////////////////
  // millisecond decision tick
  always_ff @(posedge clk_i) begin
    if (rst_i || tick_cnt == 16'(TICK_CYCLES - 1)) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick <= 1'b0;
    end else begin
      tick <= tick_cnt == 16'(TICK_CYCLES - 1);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // wishbone answer: ack one cycle after the request, one cycle wide
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req && !wb_we_i) ? next_dat : 32'h0000_0000;
    end
  end

  // read decode, unmapped words read zero
  always_comb begin
    next_dat = 32'h0000_0000;
    if (wb_adr_i[8:2] == A_CTRL[8:2]) begin
      next_dat = {30'h0, vmode, force_o};
    end else if (wb_adr_i[8:2] == A_VBASE[8:2]) begin
      next_dat = vbase;
    end else if (mem_hit) begin
      next_dat = grp_mem[midx];
    end else begin
      for (int s = 0; s < NUM_STAGES; s++) begin
        if (in_stage(wb_adr_i, s)) begin
          case (wb_adr_i[5:0])
            O_CFG:   next_dat = 32'(cfg[s]);
            O_STAT:  next_dat = {26'h0, subm[s], act_grp[s], status[s]};
            O_SCNT:  next_dat = start_count[s];
            O_TCNT:  next_dat = trip_count[s];
            O_REM:   next_dat = {16'h0, rem[s]};
            O_FRC:   next_dat = {30'h0, frc_val[s]};
            default: next_dat = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // global control: voltage mode and voltage bases
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vmode <= CTRL_RST[1];
      vbase <= VBASE_RST;
    end else if (wr && wb_adr_i[8:2] == A_CTRL[8:2] && wb_sel_i[0]) begin
      vmode <= wb_dat_i[1];
    end else if (wr && wb_adr_i[8:2] == A_VBASE[8:2]) begin
      vbase <= wmerge(vbase, wb_dat_i, wb_sel_i);
    end
  end

  // shared force flag with timeout
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      force_o <= CTRL_RST[0];
      frc_cnt <= 20'h00000;
    end else if (wr && wb_adr_i[8:2] == A_CTRL[8:2] && wb_sel_i[0]) begin
      force_o <= wb_dat_i[0];
      frc_cnt <= 20'h00000;
    end else if (force_o && tick) begin
      if (frc_cnt == 20'(FORCE_TICKS - 1)) begin
        force_o <= 1'b0;                                       // RQ19
        frc_cnt <= 20'h00000;
      end else begin
        frc_cnt <= frc_cnt + 20'h00001;
      end
    end
  end

  // stage configuration words
  always_ff @(posedge clk_i) begin
    for (int s = 0; s < NUM_STAGES; s++) begin
      if (rst_i) begin
        cfg[s] <= def_cfg_type'(CFG_RST);
      end else if (wr && in_stage(wb_adr_i, s) && wb_adr_i[5:0] == O_CFG) begin
        cfg[s] <= def_cfg_type'(wmerge(32'(cfg[s]), wb_dat_i, wb_sel_i));
      end
    end
  end

  // forced status values, writable only while the force flag is on
  always_ff @(posedge clk_i) begin
    for (int s = 0; s < NUM_STAGES; s++) begin
      if (rst_i || !force_o) begin
        frc_val[s] <= 2'b00;
      end else if (wr && in_stage(wb_adr_i, s) && wb_adr_i[5:0] == O_FRC && wb_sel_i[0]) begin
        frc_val[s] <= wb_dat_i[1:0];                           // RQ19
      end
    end
  end

  // setting group memory, three words per group per stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        case (i % GRP_WORDS)
          0:       grp_mem[i] <= {IO_PICK_RST, U0_PICK_RST};
          1:       grp_mem[i] <= {OFFSET_RST, SECTOR_RST};     // RQ23
          default: grp_mem[i] <= {DELAY_RST, INTERMIT_RST};
        endcase
      end
    end else if (wr && mem_hit) begin
      grp_mem[midx] <= wmerge(grp_mem[midx], wb_dat_i, wb_sel_i); // RQ17
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // event counters: a start or trip edge beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    for (int s = 0; s < NUM_STAGES; s++) begin
      if (rst_i) begin
        start_d[s]     <= 1'b0;
        trip_d[s]      <= 1'b0;
        start_count[s] <= 32'h0000_0000;
        trip_count[s]  <= 32'h0000_0000;
      end else begin
        start_d[s] <= start_o[s];
        trip_d[s]  <= trip_o[s];
        if (wr && wb_adr_i[8:2] == A_CLR[8:2] && wb_dat_i[s] && wb_sel_i[0]) begin
          start_count[s] <= 32'(start_o[s] && !start_d[s]);  // RQ21
        end else begin
          start_count[s] <= start_count[s] + 32'(start_o[s] && !start_d[s]);
        end
        if (wr && wb_adr_i[8:2] == A_CLR[8:2] && wb_dat_i[2+s] && wb_sel_i[0]) begin
          trip_count[s] <= 32'(trip_o[s] && !trip_d[s]);     // RQ21
        end else begin
          trip_count[s] <= trip_count[s] + 32'(trip_o[s] && !trip_d[s]);
        end
      end
    end
  end

  // stage status
  always_ff @(posedge clk_i) begin
    for (int s = 0; s < NUM_STAGES; s++) begin
      if (rst_i) begin
        status[s] <= ST_IDLE;
      end else if (blk[s]) begin
        status[s] <= ST_BLOCKED;                               // RQ20
      end else if (trip_o[s]) begin
        status[s] <= ST_TRIPPED;
      end else if (start_o[s]) begin
        status[s] <= ST_STARTED;
      end else begin
        status[s] <= ST_IDLE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per stage: group selection and decision logic
  for (genvar s = 0; s < NUM_STAGES; s++) begin : g_stage
    localparam int unsigned BASE = s * NUM_GROUPS * GRP_WORDS;
    logic [4:0] ix;

    // selector signal high picks the alternate group, else the manual one
    assign act_grp[s] = (cfg[s].src != SRC_NONE && sel_sig(sigs, cfg[s].src, cfg[s].src_idx))
                        ? GRP_ALT : cfg[s].manual_grp;         // RQ17 RQ18
    assign ix         = 5'(BASE) + 5'(act_grp[s]) * 5'(GRP_WORDS);
    assign set_sel[s] = {grp_mem[ix], grp_mem[ix + 5'd1], grp_mem[ix + 5'd2]};
    assign sub_sig[s] = sel_sig(sigs, cfg[s].subctl == SUB_VIRTUAL ? SRC_VIRTUAL : SRC_DIGITAL,
                                cfg[s].sub_idx);               // RQ7 RQ24
    assign blk[s]     = cfg[s].blocked | block_i[s];

    def_stage u_stage (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .tick_i    (tick),
      .cfg_i     (cfg[s]),
      .set_i     (set_sel[s]),
      .meas_i    (meas_i),
      .vmode_i   (vmode),
      .vbase_i   (vbase),
      .sub_sig_i (sub_sig[s]),
      .block_i   (blk[s]),
      .frc_i     (force_o),
      .frc_val_i (frc_val[s]),
      .start_o   (start_o[s]),
      .trip_o    (trip_o[s]),
      .submode_o (subm[s]),
      .rem_o     (rem[s])
    );
  end

endmodule : def_top

// ---- logic/def_pkg.sv ----
// shared constants, register map and carrier types of the earth fault stage block
package def_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned TICK_US     = 1000;
  localparam int unsigned TICK_CYC    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned FORCE_MIN   = 5;
  localparam int unsigned FORCE_TICKS = FORCE_MIN * 60 * 1_000_000 / TICK_US;

  // structure
  localparam int unsigned NUM_STAGES = 2;
  localparam int unsigned NUM_GROUPS = 4;
  localparam int unsigned GRP_WORDS  = 3;
  localparam int unsigned MEM_WORDS  = NUM_STAGES * NUM_GROUPS * GRP_WORDS;

  // byte addresses and stage-relative offsets
  localparam logic [8:0] A_CTRL    = 9'h000;
  localparam logic [8:0] A_VBASE   = 9'h004;
  localparam logic [8:0] A_CLR     = 9'h008;
  localparam logic [8:0] A_STG     = 9'h040;
  localparam logic [8:0] A_MEM     = 9'h100;
  localparam logic [5:0] O_CFG     = 6'h00;
  localparam logic [5:0] O_STAT    = 6'h04;
  localparam logic [5:0] O_SCNT    = 6'h08;
  localparam logic [5:0] O_TCNT    = 6'h0c;
  localparam logic [5:0] O_REM     = 6'h10;
  localparam logic [5:0] O_FRC     = 6'h14;

  // scaling: magnitudes in Q8 per unit, angles in 1/65536 turn
  localparam logic [15:0] IO_NOM      = 16'h0100;
  localparam logic [15:0] MEAS_SAT    = 16'(10 * IO_NOM);
  localparam logic [15:0] SUM_SAT     = 16'(50 * IO_NOM);
  localparam logic [15:0] ANG_HALF    = 16'h8000;
  localparam logic [15:0] ANG_QUARTER = 16'h4000;
  localparam logic [7:0]  PCT_FULL    = 8'h64;
  localparam logic [1:0]  GRP_ALT     = 2'h1;

  // reset values
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] VBASE_RST    = 32'h0064_0064;
  localparam logic [31:0] CFG_RST      = 32'h0000_0000;
  localparam logic [15:0] IO_PICK_RST  = 16'h0100;
  localparam logic [15:0] U0_PICK_RST  = 16'h000a;
  localparam logic [15:0] OFFSET_RST   = 16'h0000;
  localparam logic [15:0] SECTOR_RST   = 16'h3e94;
  localparam logic [15:0] DELAY_RST    = 16'h0064;
  localparam logic [15:0] INTERMIT_RST = 16'h0000;

  typedef enum logic [1:0] {MODE_OHM_CHG, MODE_SECTOR, MODE_NONDIR} def_mode_type;
  typedef enum logic [1:0] {SUB_OHMIC, SUB_CHARGING, SUB_DIGITAL, SUB_VIRTUAL} def_subctl_type;
  typedef enum logic [2:0] {SRC_NONE, SRC_DIGITAL, SRC_VIRTUAL, SRC_INDICATOR,
                            SRC_VOUT, SRC_FKEY} def_src_type;
  typedef enum logic [1:0] {ST_IDLE, ST_BLOCKED, ST_STARTED, ST_TRIPPED} def_status_type;
  typedef enum logic [1:0] {SUBM_NONE, SUBM_OHMIC, SUBM_CHARGING} def_submode_type;

  typedef struct packed {
    logic [13:0]    pad;
    logic           blocked;
    logic [2:0]     sub_idx;
    logic [2:0]     src_idx;
    def_src_type    src;
    logic [1:0]     manual_grp;
    logic           inverse;
    logic           summed;
    def_subctl_type subctl;
    def_mode_type   mode;
  } def_cfg_type;

  typedef struct packed {
    logic [15:0] io_pick;
    logic [15:0] u0_pick;
    logic [15:0] offset;
    logic [15:0] half;
    logic [15:0] delay;
    logic [15:0] intermit;
  } def_set_type;

  typedef struct packed {
    logic [15:0] io_mag;
    logic [15:0] io_ang;
    logic [15:0] sum_mag;
    logic [15:0] sum_ang;
    logic [15:0] u0m_mag;
    logic [15:0] u0c_mag;
    logic [15:0] u0_ang;
  } def_meas_type;

endpackage : def_pkg

// ---- logic/def_stage.sv ----
// one directional earth fault stage: pick-up criterion, delay and time-to-trip
`timescale 1ns/1ps
module def_stage (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 tick_i,
  input  wire def_pkg::def_cfg_type  cfg_i,
  input  wire def_pkg::def_set_type  set_i,
  input  wire def_pkg::def_meas_type meas_i,
  input  wire logic                 vmode_i,
  input  wire logic [31:0]          vbase_i,
  input  wire logic                 sub_sig_i,
  input  wire logic                 block_i,
  input  wire logic                 frc_i,
  input  wire logic [1:0]           frc_val_i,
  output logic                      start_o,
  output logic                      trip_o,
  output def_pkg::def_submode_type  submode_o,
  output logic [15:0]               rem_o
);
  import def_pkg::*;

  // positive half of a coarse cosine, Q8
  function automatic logic [8:0] cos_q8(input logic [15:0] a);
    logic [15:0] t;
    t = a[14] ? 16'(-a) : a;
    cos_q8 = 9'h000;
    if (a[15] == a[14]) begin
      case (t[13:10])
        4'h0: cos_q8 = 9'h100;  4'h1: cos_q8 = 9'h0ff;
        4'h2: cos_q8 = 9'h0fb;  4'h3: cos_q8 = 9'h0f5;
        4'h4: cos_q8 = 9'h0ed;  4'h5: cos_q8 = 9'h0e2;
        4'h6: cos_q8 = 9'h0d5;  4'h7: cos_q8 = 9'h0c6;
        4'h8: cos_q8 = 9'h0b5;  4'h9: cos_q8 = 9'h0a2;
        4'ha: cos_q8 = 9'h08e;  4'hb: cos_q8 = 9'h079;
        4'hc: cos_q8 = 9'h062;  4'hd: cos_q8 = 9'h04a;
        4'he: cos_q8 = 9'h032;  default: cos_q8 = 9'h019;
      endcase
    end
  endfunction : cos_q8

  logic [15:0] mag, ang, dlt, adist, u0mag;
  logic [31:0] u0lhs, u0rhs, comp, target, inc, acc, next_acc;
  logic [32:0] sum;
  logic [15:0] intm;
  logic        u0ok, pick, charging;
  logic [31:0] dq, dr;
  logic [5:0]  dn;

  //////////////////////////////////////////////////////////////////////////
  // pick-up criterion on fundamental phasors
  always_comb begin
    mag = cfg_i.summed ? meas_i.sum_mag : meas_i.io_mag;         // RQ12 RQ3
    if (mag > (cfg_i.summed ? SUM_SAT : MEAS_SAT)) begin
      mag = cfg_i.summed ? SUM_SAT : MEAS_SAT;                   // RQ16
    end
    ang   = cfg_i.summed ? meas_i.sum_ang : meas_i.io_ang;
    dlt   = ang - meas_i.u0_ang - ANG_HALF - set_i.offset;       // RQ4
    adist = dlt[15] ? 16'(-dlt) : dlt;
    u0mag = vmode_i ? meas_i.u0m_mag : meas_i.u0c_mag;           // RQ5 RQ6
    u0lhs = 32'(u0mag) * 32'(PCT_FULL);
    u0rhs = 32'(set_i.u0_pick) * 32'(vmode_i ? vbase_i[31:16] : vbase_i[15:0]); // RQ5 RQ6
    u0ok  = u0lhs >= u0rhs;
    case (cfg_i.subctl)
      SUB_OHMIC:    charging = 1'b0;                             // RQ24
      SUB_CHARGING: charging = 1'b1;
      default:      charging = sub_sig_i;                        // RQ7
    endcase
    comp = (32'(mag) * 32'(cos_q8(charging ? 16'(dlt - ANG_QUARTER) : dlt))) >> 8;
    case (cfg_i.mode)
      MODE_OHM_CHG: pick = u0ok && comp >= 32'(set_i.io_pick);   // RQ8 RQ9
      MODE_SECTOR:  pick = u0ok && adist <= set_i.half && mag >= set_i.io_pick; // RQ10
      MODE_NONDIR:  pick = mag >= set_i.io_pick;                 // RQ11
      default:      pick = 1'b0;
    endcase
    target   = 32'(set_i.delay) * 32'(set_i.io_pick);
    inc      = cfg_i.inverse ? 32'(mag) : 32'(set_i.io_pick);    // RQ14 RQ15
    sum      = 33'(acc) + 33'(inc);
    next_acc = (sum >= 33'(target)) ? target : sum[31:0];
  end

  // delay accumulator with intermittent hold
  always_ff @(posedge clk_i) begin
    if (rst_i || block_i) begin
      acc  <= 32'h0000_0000;
      intm <= 16'h0000;
    end else if (tick_i) begin
      if (pick) begin
        acc  <= next_acc;                                        // RQ13
        intm <= 16'h0000;
      end else if (acc != 32'h0000_0000) begin
        if (intm >= set_i.intermit) begin
          acc  <= 32'h0000_0000;                                 // RQ25
          intm <= 16'h0000;
        end else begin
          intm <= intm + 16'h0001;
        end
      end
    end
  end

  // start and trip outputs
  always_ff @(posedge clk_i) begin
    if (rst_i || block_i) begin
      start_o <= 1'b0;                                           // RQ26
      trip_o  <= 1'b0;
    end else if (frc_i) begin
      start_o <= frc_val_i[0];                                   // RQ19
      trip_o  <= frc_val_i[1];
    end else begin
      start_o <= pick;                                           // RQ1
      trip_o  <= pick && acc >= target;                          // RQ2
    end
  end

  // submode in use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      submode_o <= SUBM_NONE;
    end else if (cfg_i.mode != MODE_OHM_CHG) begin
      submode_o <= SUBM_NONE;
    end else begin
      submode_o <= charging ? SUBM_CHARGING : SUBM_OHMIC;
    end
  end

  // serial divider: ticks left = (target - acc) / inc, restarted on a tick once idle
  // so that a tick period shorter than the 32 steps still lets a result through
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dq    <= 32'h0000_0000;
      dr    <= 32'h0000_0000;
      dn    <= 6'h00;
      rem_o <= 16'h0000;
    end else if (tick_i && dn == 6'h00) begin
      dq <= (target > acc) ? target - acc : 32'h0000_0000;
      dr <= 32'h0000_0000;
      dn <= 6'h20;
    end else if (dn != 6'h00) begin
      if ({dr[30:0], dq[31]} >= inc) begin
        dr <= {dr[30:0], dq[31]} - inc;
        dq <= {dq[30:0], 1'b1};
      end else begin
        dr <= {dr[30:0], dq[31]};
        dq <= {dq[30:0], 1'b0};
      end
      dn <= dn - 6'h01;
      if (dn == 6'h01) begin
        rem_o <= !start_o ? 16'h0000 : (dq[30:15] != 16'h0000) ? 16'hffff
               : {dq[14:0], {dr[30:0], dq[31]} >= inc};          // RQ22
      end
    end
  end

endmodule : def_stage

// ---- dv/def_fe_model.sv ----
// front end model: fundamental phasors handed to the stages
`timescale 1ns/1ps
module def_fe_model (
  input  wire logic [15:0]      io_mag_i,
  output def_pkg::def_meas_type meas_o
);
  import def_pkg::*;
  // 1 pu u0 on both paths at half a turn, so the residual sits at 0 deg to -u0
  assign meas_o = '{io_mag_i, 16'h0000, io_mag_i, 16'h0000, IO_NOM, IO_NOM, ANG_HALF};
endmodule : def_fe_model

// ---- dv/def_top_asserts.sv ----
// port checks for the earth fault block
`timescale 1ns/1ps
module def_chk #(parameter int unsigned TICK_CYCLES = 10, FORCE_TICKS = 5) (
  input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, force_o,
  input wire logic [8:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [1:0]  block_i, start_o, trip_o
);
  localparam int F_MAX = TICK_CYCLES * FORCE_TICKS + 20;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; req |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("long ack");
  property p_dat; !wb_ack_o |-> wb_dat_o == 0; endproperty
  a_dat: assert property (p_dat) else $error("stray data");
  property p_blk0; block_i[0] |=> !start_o[0] && !trip_o[0]; endproperty
  a_blk0: assert property (p_blk0) else $error("stage 0 active");
  property p_blk1; block_i[1] |=> !start_o[1] && !trip_o[1]; endproperty
  a_blk1: assert property (p_blk1) else $error("stage 1 active");
  property p_trip; trip_o[0] && !force_o && !$past(force_o) |-> start_o[0]; endproperty
  a_trip: assert property (p_trip) else $error("trip alone");
  property p_fset; req && wb_we_i && wb_adr_i[8:2] == 0 && wb_sel_i[0] && wb_dat_i[0] |=> force_o; endproperty
  a_fset: assert property (p_fset) else $error("force not set");
  property p_fend; $rose(force_o) |-> ##[1:F_MAX] !force_o; endproperty
  a_fend: assert property (p_fend) else $error("force stuck");
  // main scenarios
  c_trip: cover property ($rose(trip_o[0]));
  c_frc: cover property ($fell(force_o));
  c_blk: cover property (block_i[0] && start_o[0]);
endmodule : def_chk
bind def_top def_chk #(.TICK_CYCLES(TICK_CYCLES), .FORCE_TICKS(FORCE_TICKS)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .force_o(force_o), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .block_i(block_i), .start_o(start_o),
  .trip_o(trip_o));

// ---- dv/tb_top.sv ----
// bench for the earth fault block
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value %0t %h %h", $time, a, b); end end
module tb_top;
  import def_pkg::*;
  logic         clk_i = 0, rst_i = 1, cyc = 0, we = 0, ack, frc;
  logic [8:0]   adr = 0;
  logic [31:0]  dat = 0, rd, q;
  logic [15:0]  io = 0;
  logic [1:0]   blk = 0, st, tr;
  logic [7:0]   di = 0;
  logic [3:0]   sel = 4'hf;
  def_meas_type meas;
  int           n_mismatch = 0, checks = 0, cycles = 0, n;
  // rows: residual magnitude, block, expected start
  logic [17:0]  rows [4] = '{18'h00200, 18'h00c01, 18'h00c02, 18'h00801};
  def_fe_model fe_u (.io_mag_i(io), .meas_o(meas));
  def_top #(.TICK_CYCLES(10), .FORCE_TICKS(5)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .meas_i(meas), .digital_input_n_i(di), .virtual_input_n_i(8'h00),
    .indicator_signal_n_i(8'h00), .virtual_output_n_i(8'h00), .function_key_n_i(8'h00),
    .block_i(blk), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(q), .wb_ack_o(ack), .start_o(st),
    .trip_o(tr), .force_o(frc));
  // 100 ns clock and hang guard
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  // one classic bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, we, adr, dat} <= {1'b1, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = q;
    cyc <= 1'b0;
  endtask : wb
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  // reset, row loop, then registers, trip, counters and force
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK({st, tr, frc}, 5'h00)
    foreach (rows[i]) begin
      @(posedge clk_i);
      {io, blk} <= {rows[i][17:2], {2{rows[i][1]}}};
      repeat (3) @(posedge clk_i);
      `CHK(st, {2{rows[i][0]}})
    end
    wb(0, 9'h004, 0);
    `CHK(rd, VBASE_RST)
    wb(0, 9'h104, 0);
    `CHK(rd, {OFFSET_RST, SECTOR_RST})
    wb(0, 9'h0fc, 0);
    `CHK(rd, 32'h0000_0000)
    repeat (200) @(posedge clk_i);
    wb(0, 9'h050, 0);
    `CHK(rd > 0 && rd < 32'(DELAY_RST), 1'b1)
    for (n = 203; tr[0] !== 1'b1; n++) @(posedge clk_i);
    `CHK(n > 960, 1'b1)
    wb(0, 9'h04c, 0);
    `CHK(rd, 32'h0000_0001)
    wb(1, 9'h008, 32'h0000_000c);
    wb(0, 9'h04c, 0);
    `CHK(rd, 32'h0000_0000)
    wb(1, 9'h000, 32'h0000_0001);
    `CHK(frc, 1'b1)
    repeat (3) @(posedge clk_i);
    `CHK({st, tr}, 4'h0)
    for (n = 0; frc !== 1'b0; n++) @(posedge clk_i);
    `CHK(n > 35, 1'b1)
    // stage 1 follows digital input 0 to group 1, whose pick-up is out of reach
    di <= 8'h01;
    wb(1, 9'h080, 32'h0000_0100);
    wb(1, 9'h13c, 32'hffff_000a);
    wb(0, 9'h084, 0);
    `CHK(rd[5:0], 6'h14)
    `CHK(st, 2'b01)
    // a control write with no byte enabled must leave the force flag alone
    sel <= 4'h0;
    wb(1, 9'h000, 32'h0000_0001);
    `CHK(frc, 1'b0)
    summarize();
  end
endmodule : tb_top
